/* File: sim/rfc_peer_model.sv */
// Behavioural model of the peer card facing the failover block
module rfc_peer_model (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // Local card state and bench command
    input  wire logic          local_active,
    input  wire logic          fail_cmd,
    // Peer status toward the local card
    output rfc_pkg::rfc_peer_t peer
);
    timeunit 1ns;
    timeprecision 1ns;
    import rfc_pkg::*;

    logic [1:0] idle_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            idle_r <= 2'h0;
            peer   <= '0;
        end else begin
            idle_r <= local_active ? 2'h0
                    : (idle_r == 2'h3 ? idle_r : idle_r + 2'h1);
            peer.fault <= fail_cmd;
            // take over only once local side stays idle
            peer.active <= !fail_cmd
                         && (peer.active || (idle_r == 2'h3 && !local_active));
        end
    end
endmodule

/* File: sim/rfc_top_tb.sv */
// Self-checking bench for the failover control block
module rfc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rfc_pkg::*;

    localparam int SUP = 20;
    localparam int FB  = 50;
    localparam int RET = 16;

    logic clk = 1'b0, reset_n = 1'b0;
    rfc_calc_t calc = '0;
    rfc_peer_t peer;
    logic [1:0] bad_access = 2'h0, bus_err = 2'h0, retest_ok = 2'h0;
    logic sup_kick = 1'b0, diag_done = 1'b0, diag_hw_ok = 1'b0;
    logic slot_primary = 1'b1, upset_en = 1'b0, remote_variant = 1'b0;
    logic [3:0] mem_raddr = 4'h0, upset_addr = 4'h0, upset_bit = 4'h0;
    logic pio_fault = 1'b0, bus_xfer = 1'b0, io_access = 1'b0, fb_hold = 1'b0;
    logic [7:0] io_wdata = 8'h00, fb_preset = 8'h00, io_val = 8'h00;
    logic active_r, cpu_fault_r, diag_start_r, card_failed_r, sup_expired_r;
    logic bus_valid_r, bus_master_r, bus_diag_only_r, bus_sel_r;
    logic mem_corrected_r, fallback_r, kick_en = 1'b1, acc_en = 1'b1;
    logic fail_cmd = 1'b0;
    logic [1:0] cpu_halt_r, bus_bad_r, retest_req_r;
    logic [7:0] bus_data_r, mem_rdata_r, io_out_r, r;
    int error_cnt = 0, n_compared = 0, n, exp_sel, exp_bad;
    int mem [16];

    always #50 clk = ~clk;

    rfc_top #(.SUP_CYC_P(SUP), .FB_CYC_P(FB), .RETEST_CYC_P(RET)) i_dut (
        .clk, .reset_n, .calc, .bad_access, .sup_kick, .diag_done,
        .diag_hw_ok, .peer, .slot_primary, .mem_raddr, .upset_en,
        .upset_addr, .upset_bit, .remote_variant, .pio_fault, .bus_xfer,
        .bus_err, .retest_ok, .io_access, .io_wdata, .fb_hold, .fb_preset,
        .active_r, .cpu_fault_r, .cpu_halt_r, .diag_start_r, .card_failed_r,
        .sup_expired_r, .bus_data_r, .bus_valid_r, .bus_master_r,
        .bus_diag_only_r, .bus_sel_r, .bus_bad_r, .retest_req_r,
        .mem_rdata_r, .mem_corrected_r, .io_out_r, .fallback_r
    );

    rfc_peer_model i_peer (
        .clk, .reset_n, .local_active(active_r), .fail_cmd, .peer
    );

    // Keep-alive traffic from the processors
    always @(posedge clk) begin
        sup_kick  <= kick_en;
        io_access <= acc_en;
        io_wdata  <= io_val;
    end

    always @(negedge clk) begin
        if (reset_n) chk(active_r & peer.active, 0);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Bounded wait for one of several events
    task automatic wait_on(input int w, input int lim, output int k);
        logic hit;
        hit = 1'b0;
        k = 0;
        while (!hit && k < lim) begin
            @(posedge clk);
            #1;
            k++;
            case (w)
                0: hit = sup_expired_r === 1'b1;
                1: hit = fallback_r === 1'b1;
                2: hit = retest_req_r !== 2'h0;
                3: hit = peer.active === 1'b1;
                default: hit = active_r === 1'b1;
            endcase
        end
        chk(hit, 1);
        if (!hit) wrap_up();
    endtask

    task automatic calc_op(input logic [7:0] a, input logic [7:0] b,
                           input logic [3:0] ad, input logic [1:0] bad);
        @(posedge clk);
        calc <= '{res_a: a, res_b: b, addr: ad, valid: 1'b1};
        bad_access <= bad;
        @(posedge clk);
        calc.valid <= 1'b0;
        bad_access <= 2'h0;
        #1;
    endtask

    task automatic bus_op(input logic x, input logic [1:0] e,
                          input logic [1:0] ok);
        @(posedge clk);
        bus_xfer <= x;
        bus_err <= e;
        retest_ok <= ok;
        @(posedge clk);
        bus_xfer <= 1'b0;
        bus_err <= 2'h0;
        retest_ok <= 2'h0;
        #1;
    endtask

    task automatic diag(input logic ok);
        @(posedge clk);
        diag_done <= 1'b1;
        diag_hw_ok <= ok;
        @(posedge clk);
        diag_done <= 1'b0;
        #1;
    endtask

    initial begin
        void'($urandom(20));
        repeat (5) @(posedge clk);
        #1;
        chk({active_r, cpu_fault_r, cpu_halt_r, bus_valid_r, bus_sel_r,
             bus_bad_r, fallback_r, bus_master_r}, 0);
        chk({bus_data_r, io_out_r}, 0);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(active_r, 1);
        chk({bus_master_r, bus_diag_only_r}, 2'h2);
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom);
            calc_op(r, r, 4'(i), 2'h0);
            chk(bus_valid_r, 1);
            chk(bus_data_r, r);
            mem[i] = r;
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            upset_en <= 1'b1;
            upset_addr <= 4'(i);
            upset_bit <= 4'($urandom % 12);
            mem_raddr <= 4'(i);
            @(posedge clk);
            upset_en <= 1'b0;
            @(posedge clk);
            #1;
            chk(mem_rdata_r, mem[i]);
            chk(mem_corrected_r, 1);
        end
        exp_sel = 0;
        for (int i = 0; i < 3; i++) begin
            bus_op(1'b1, 2'h0, 2'h0);
            exp_sel ^= 1;
            chk(bus_sel_r, exp_sel);
        end
        exp_bad = 1 << exp_sel;
        bus_op(1'b0, 2'(exp_bad), 2'h0);
        exp_sel ^= 1;
        chk(bus_bad_r, exp_bad);
        chk(bus_sel_r, exp_sel);
        bus_op(1'b1, 2'h0, 2'h0);
        chk(bus_sel_r, exp_sel);
        wait_on(2, RET + 3, n);
        chk(retest_req_r, exp_bad);
        bus_op(1'b0, 2'h0, 2'(exp_bad));
        chk(bus_bad_r, 0);
        bus_op(1'b1, 2'h0, 2'h0);
        chk(bus_sel_r, exp_sel ^ 1);
        for (int h = 0; h < 2; h++) begin
            io_val = 8'($urandom);
            fb_preset <= 8'($urandom);
            fb_hold <= h[0];
            repeat (3) @(posedge clk);
            acc_en <= 1'b0;
            wait_on(1, FB + 5, n);
            chk(io_out_r, h ? io_val : fb_preset);
            chk(n >= FB && n <= FB + 3, 1);
            acc_en = 1'b1;
            io_val = ~io_val;
            repeat (3) @(posedge clk);
            #1;
            chk({fallback_r, io_out_r}, {1'b0, io_val});
        end
        r = 8'($urandom);
        calc_op(r, r ^ 8'h01, 4'h1, 2'h0);
        chk({cpu_fault_r, active_r, diag_start_r}, 3'h5);
        calc_op(8'(~mem[0]), 8'(~mem[0]), 4'h0, 2'h1);
        chk(bus_valid_r, 0);
        chk(cpu_halt_r, 1);
        mem_raddr <= 4'h0;
        repeat (2) @(posedge clk);
        #1;
        chk(mem_rdata_r, mem[0]);
        wait_on(3, 8, n);
        remote_variant <= 1'b1;
        r = 8'($urandom);
        calc_op(r, r, 4'h2, 2'h0);
        chk({bus_valid_r, bus_data_r}, {1'b0, r});
        chk({bus_diag_only_r, bus_master_r}, 2'h2);
        remote_variant <= 1'b0;
        diag(1'b1);
        chk({cpu_halt_r, card_failed_r, active_r}, 0);
        fail_cmd <= 1'b1;
        wait_on(4, 6, n);
        kick_en = 1'b0;
        wait_on(0, SUP + 6, n);
        chk(n >= SUP && n <= SUP + 3, 1);
        chk(active_r, 0);
        kick_en = 1'b1;
        diag(1'b1);
        wait_on(4, 6, n);
        calc_op(8'h3C, 8'h3C, 4'h3, 2'h1);
        chk({cpu_halt_r, active_r, bus_valid_r}, 4'h4);
        diag(1'b1);
        wait_on(4, 6, n);
        @(posedge clk);
        pio_fault <= 1'b1;
        @(posedge clk);
        pio_fault <= 1'b0;
        #1;
        chk(active_r, 0);
        diag(1'b0);
        repeat (4) @(posedge clk);
        #1;
        chk({card_failed_r, active_r}, 2'h2);
        wrap_up();
    end
endmodule

/* File: verilog/rfc_pkg.sv */
// Shared constants, types and ECC helpers for failover control
package rfc_pkg;

    // Data path widths
    localparam int DATA_W     = 8;
    localparam int CODE_W     = 12;
    localparam int ADDR_W     = 4;
    localparam int MEM_DEPTH  = 16;

    // Timing
    localparam int CLK_HZ      = 10_000_000;
    localparam int SUP_TIME_US = 1000;
    localparam int SUP_CYC     = SUP_TIME_US * (CLK_HZ / 1_000_000);
    localparam int FB_TIME_S   = 4;
    localparam int FB_CYC      = FB_TIME_S * CLK_HZ;
    localparam int RETEST_MS   = 10;
    localparam int RETEST_CYC  = RETEST_MS * (CLK_HZ / 1000);

    // Reset values
    localparam logic [DATA_W-1:0] IO_OUT_RST  = 8'h00;
    localparam logic [DATA_W-1:0] BUS_DAT_RST = 8'h00;
    localparam logic              BUS_SEL_RST = 1'h0;

    typedef struct packed {
        logic [DATA_W-1:0] res_a;
        logic [DATA_W-1:0] res_b;
        logic [ADDR_W-1:0] addr;
        logic              valid;
    } rfc_calc_t;

    typedef struct packed {
        logic active;
        logic fault;
    } rfc_peer_t;

    typedef enum {
        RFC_STANDBY,
        RFC_ACTIVE,
        RFC_DIAG,
        RFC_FAILED
    } rfc_role_t;

    // Hamming encode, parity at positions 1, 2, 4, 8
    function automatic logic [CODE_W-1:0] rfc_enc(
        input logic [DATA_W-1:0] d);
        logic [CODE_W-1:0] c;
        int                j;
        c = '0;
        j = 0;
        for (int i = 1; i <= CODE_W; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i-1] = d[j];
                j++;
            end
        end
        for (int k = 0; k < 4; k++) begin
            for (int i = 1; i <= CODE_W; i++) begin
                if (i[k] && i != (1 << k)) begin
                    c[(1<<k)-1] = c[(1<<k)-1] ^ c[i-1];
                end
            end
        end
        return c;
    endfunction

    function automatic logic [3:0] rfc_syn(
        input logic [CODE_W-1:0] c);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 1; i <= CODE_W; i++) begin
            if (c[i-1]) begin
                s = s ^ i[3:0];
            end
        end
        return s;
    endfunction

    function automatic logic [DATA_W-1:0] rfc_fix(
        input logic [CODE_W-1:0] c);
        logic [CODE_W-1:0] f;
        logic [3:0]        s;
        logic [DATA_W-1:0] d;
        int                j;
        f = c;
        s = rfc_syn(c);
        d = '0;
        j = 0;
        if (s != 4'h0 && int'(s) <= CODE_W) begin
            f[s-4'h1] = ~f[s-4'h1];
        end
        for (int i = 1; i <= CODE_W; i++) begin
            if ((i & (i - 1)) != 0) begin
                d[j] = f[i-1];
                j++;
            end
        end
        return d;
    endfunction

endpackage

/* File: verilog/rfc_top.sv */
// Duplexed card supervision, bus redundancy and output fallback
module rfc_top #(
    parameter int SUP_CYC_P    = rfc_pkg::SUP_CYC,
    parameter int FB_CYC_P     = rfc_pkg::FB_CYC,
    parameter int RETEST_CYC_P = rfc_pkg::RETEST_CYC
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    // Lockstep processor pair
    input  wire rfc_pkg::rfc_calc_t           calc,
    input  wire logic [1:0]                   bad_access,
    input  wire logic                         sup_kick,
    input  wire logic                         diag_done,
    input  wire logic                         diag_hw_ok,
    // Peer card
    input  wire rfc_pkg::rfc_peer_t           peer,
    input  wire logic                         slot_primary,
    // Main memory read and upset model
    input  wire logic [rfc_pkg::ADDR_W-1:0]   mem_raddr,
    input  wire logic                         upset_en,
    input  wire logic [rfc_pkg::ADDR_W-1:0]   upset_addr,
    input  wire logic [3:0]                   upset_bit,
    // I/O bus side
    input  wire logic                         remote_variant,
    input  wire logic                         pio_fault,
    input  wire logic                         bus_xfer,
    input  wire logic [1:0]                   bus_err,
    input  wire logic [1:0]                   retest_ok,
    // I/O module output
    input  wire logic                         io_access,
    input  wire logic [rfc_pkg::DATA_W-1:0]   io_wdata,
    input  wire logic                         fb_hold,
    input  wire logic [rfc_pkg::DATA_W-1:0]   fb_preset,
    // Card status
    output logic                              active_r,
    output logic                              cpu_fault_r,
    output logic [1:0]                        cpu_halt_r,
    output logic                              diag_start_r,
    output logic                              card_failed_r,
    output logic                              sup_expired_r,
    // Bus interface
    output logic [rfc_pkg::DATA_W-1:0]        bus_data_r,
    output logic                              bus_valid_r,
    output logic                              bus_master_r,
    output logic                              bus_diag_only_r,
    output logic                              bus_sel_r,
    output logic [1:0]                        bus_bad_r,
    output logic [1:0]                        retest_req_r,
    // Memory read data
    output logic [rfc_pkg::DATA_W-1:0]        mem_rdata_r,
    output logic                              mem_corrected_r,
    // I/O module drive
    output logic [rfc_pkg::DATA_W-1:0]        io_out_r,
    output logic                              fallback_r
);
    import rfc_pkg::*;

    rfc_role_t         role_r;
    rfc_role_t         role_nxt;
    logic [31:0]       sup_cnt_r;
    logic [31:0]       fb_cnt_r;
    logic [31:0]       fb_cnt_nxt;
    logic [31:0]       rt_cnt_r;
    logic [CODE_W-1:0] mem [MEM_DEPTH];
    logic [CODE_W-1:0] mem_word;

    wire same_w     = calc.res_a == calc.res_b;
    wire bad_w      = |bad_access;
    wire mismatch_w = calc.valid && !same_w;
    wire agree_w    = calc.valid && same_w && !bad_w;
    wire lfault_w   = mismatch_w || bad_w;
    wire sup_exp_w  = sup_cnt_r == SUP_CYC_P;
    // take over only from an idle peer
    wire may_take_w = !peer.active &&
                      (peer.fault || slot_primary);
    wire diag_pass_w = role_r == RFC_DIAG &&
                       diag_done && diag_hw_ok;
    wire act_nxt_w  = role_nxt == RFC_ACTIVE;

    // Role sequencing
    always_comb begin
        role_nxt = role_r;
        case (role_r)
            RFC_STANDBY: begin
                if (lfault_w) begin
                    role_nxt = RFC_DIAG;
                end else if (may_take_w) begin
                    role_nxt = RFC_ACTIVE;
                end
            end
            RFC_ACTIVE: begin
                if (lfault_w || sup_exp_w || pio_fault) begin
                    role_nxt = RFC_DIAG;
                end else if (peer.active && !slot_primary) begin
                    role_nxt = RFC_STANDBY;
                end
            end
            RFC_DIAG: begin
                if (diag_done) begin
                    role_nxt = diag_hw_ok ? RFC_STANDBY
                                          : RFC_FAILED;
                end
            end
            default: begin
                role_nxt = RFC_FAILED;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            role_r        <= RFC_STANDBY;
            active_r      <= 1'b0;
            cpu_fault_r   <= 1'b0;
            diag_start_r  <= 1'b0;
            card_failed_r <= 1'b0;
        end else begin
            role_r        <= role_nxt;
            active_r      <= act_nxt_w;
            cpu_fault_r   <= mismatch_w;
            diag_start_r  <= role_nxt == RFC_DIAG &&
                             role_r != RFC_DIAG;
            card_failed_r <= role_nxt == RFC_FAILED;
        end
    end

    // supervision timer on the active card
    always_ff @(posedge clk) begin
        if (!reset_n || role_r != RFC_ACTIVE || sup_kick) begin
            sup_cnt_r <= 32'h0;
        end else if (!sup_exp_w) begin
            sup_cnt_r <= sup_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sup_expired_r <= 1'b0;
        end else begin
            sup_expired_r <= sup_exp_w;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpu_halt_r <= 2'h0;
        end else begin
            cpu_halt_r <= bad_access |
                          (cpu_halt_r & {2{!diag_pass_w}});
        end
    end

    // ECC memory, bad data never stored
    assign mem_word = mem[mem_raddr];

    always_ff @(posedge clk) begin
        if (agree_w) begin
            mem[calc.addr] <= rfc_enc(calc.res_a);
        end
        if (upset_en && int'(upset_bit) < CODE_W) begin
            mem[upset_addr][upset_bit] <=
                ~mem[upset_addr][upset_bit];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_rdata_r     <= BUS_DAT_RST;
            mem_corrected_r <= 1'b0;
        end else begin
            mem_rdata_r     <= rfc_fix(mem_word);
            mem_corrected_r <= rfc_syn(mem_word) != 4'h0;
        end
    end

    // both cards keep fresh results; only active sends
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bus_data_r  <= BUS_DAT_RST;
            bus_valid_r <= 1'b0;
        end else begin
            if (agree_w) begin
                bus_data_r <= calc.res_a;
            end
            bus_valid_r <= agree_w && role_r == RFC_ACTIVE;
        end
    end

    // bus interface role follows the card
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bus_master_r    <= 1'b0;
            bus_diag_only_r <= 1'b0;
        end else begin
            bus_master_r    <= act_nxt_w;
            bus_diag_only_r <= remote_variant && !act_nxt_w;
        end
    end

    // Per-bus abnormal flags
    logic [1:0] bad_nxt;
    for (genvar i = 0; i < 2; i++) begin : g_bus
        // error wins over a passing retest
        assign bad_nxt[i] = bus_err[i] |
                            (bus_bad_r[i] & !retest_ok[i]);
    end

    // alternate, steer off an abnormal bus
    wire other_w   = ~bus_sel_r;
    wire sel_nxt_w = (!bad_nxt[other_w] &&
                      (bad_nxt[bus_sel_r] || bus_xfer))
                     ? other_w : bus_sel_r;
    wire rt_tick_w = rt_cnt_r == RETEST_CYC_P - 1;

    always_ff @(posedge clk) begin
        if (!reset_n || rt_tick_w) begin
            rt_cnt_r <= 32'h0;
        end else begin
            rt_cnt_r <= rt_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bus_sel_r    <= BUS_SEL_RST;
            bus_bad_r    <= 2'h0;
            retest_req_r <= 2'h0;
        end else begin
            bus_sel_r    <= sel_nxt_w;
            bus_bad_r    <= bad_nxt;
            retest_req_r <= {2{rt_tick_w}} & bus_bad_r;
        end
    end

    wire fb_clr_w = io_access && !sup_exp_w;

    always_comb begin
        if (fb_clr_w) begin
            fb_cnt_nxt = 32'h0;
        end else if (fb_cnt_r == FB_CYC_P) begin
            fb_cnt_nxt = fb_cnt_r;
        end else begin
            fb_cnt_nxt = fb_cnt_r + 32'h1;
        end
    end

    wire fb_nxt_w = fb_cnt_nxt == FB_CYC_P;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fb_cnt_r   <= 32'h0;
            fallback_r <= 1'b0;
            io_out_r   <= IO_OUT_RST;
        end else begin
            fb_cnt_r   <= fb_cnt_nxt;
            fallback_r <= fb_nxt_w;
            if (fb_clr_w) begin
                io_out_r <= io_wdata;
            end else if (fb_nxt_w && !fallback_r && !fb_hold) begin
                io_out_r <= fb_preset;
            end
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_mismatch_drops: assert property (
        mismatch_w |=> !active_r && cpu_fault_r)
        else $error("mismatch left card active");

    chk_agree_forward: assert property (
        agree_w && role_r == RFC_ACTIVE |=>
        bus_valid_r && bus_data_r == $past(calc.res_a))
        else $error("agreed result not forwarded");

    chk_halt_on_bad: assert property (
        bad_access[0] |=> cpu_halt_r[0] && !active_r)
        else $error("bad access did not halt");

    chk_sup_expiry: assert property (
        role_r == RFC_ACTIVE && !sup_kick && !lfault_w
        && !pio_fault && !peer.active
        && sup_cnt_r == SUP_CYC_P - 1 |-> ##2 !active_r)
        else $error("supervision expiry ignored");

    chk_single_active: assert property (
        $rose(active_r) |-> $past(!peer.active))
        else $error("took over from active peer");

    chk_fb_leave: assert property (
        fb_clr_w |=> !fallback_r && io_out_r == $past(io_wdata))
        else $error("fallback not left on access");

    chk_fb_enter: assert property (
        $rose(fallback_r) |-> $past(fb_cnt_r) == FB_CYC_P - 1)
        else $error("fallback at wrong time");

    chk_bus_steer: assert property (
        bus_err[bus_sel_r] && !bus_err[!bus_sel_r]
        && !bus_bad_r[!bus_sel_r] |=>
        bus_sel_r != $past(bus_sel_r) && bus_bad_r[$past(bus_sel_r)])
        else $error("bus not steered off fault");

    chk_retest_clear: assert property (
        bus_bad_r[1] && retest_ok[1] && !bus_err[1] |=>
        !bus_bad_r[1])
        else $error("retested bus not restored");

    chk_diag_return: assert property (
        diag_pass_w |=> role_r == RFC_STANDBY [*1] ##1
        !cpu_halt_r[0] || $past(bad_access[0]))
        else $error("diagnosed card not standby");

    chk_remote_idle: assert property (
        remote_variant && !act_nxt_w |=>
        bus_diag_only_r && !bus_master_r)
        else $error("remote standby not idle");

endmodule
